// ### inc/cpm_params.svh
`ifndef CPM_PARAMS_SVH
`define CPM_PARAMS_SVH

// register byte offsets
`define CPM_CTRL_OFS       12'h000
`define CPM_MODE_OFS       12'h004
`define CPM_SRC_OFS        12'h008
`define CPM_STAT_OFS       12'h00C
`define CPM_IRQ_STAT_OFS   12'h010
`define CPM_IRQ_MASK_OFS   12'h014
`define CPM_PCG_OFS        12'h018
`define CPM_DIV_OFS        12'h01C
`define CPM_RTC_CNT_OFS    12'h020
`define CPM_RTC_ALM_OFS    12'h024
`define CPM_RTC_PER_OFS    12'h028

// interrupt status bit positions
`define CPM_IRQ_XFAIL      0
`define CPM_IRQ_XRDY       1
`define CPM_IRQ_ALARM      2
`define CPM_IRQ_PERIOD     3
`define CPM_IRQ_WAKE       4

// control bit positions
`define CPM_CTRL_SLOW_LP   0
`define CPM_CTRL_STOP_OSC  1
`define CPM_CTRL_STOP_REG  2
`define CPM_CTRL_KEEP_XTAL 3
`define CPM_CTRL_KEEP_FL   4
`define CPM_CTRL_KEEP_REG  5
`define CPM_CTRL_RTC_RUN   6
`define CPM_CTRL_LP_SEL    7

// reset values
`define CPM_CTRL_RST       8'h40
`define CPM_DIV_RST        8'h00
`define CPM_RTC_PER_RST    16'h0100

// timing: crystal start-up in microseconds, clock 10 MHz in MHz
`define CPM_CLK_MHZ        10
`define CPM_XTAL_START_US  1000
`define CPM_XTAL_START_CYC (`CPM_XTAL_START_US * `CPM_CLK_MHZ)
// crystal loss: no edge for this many cycles
`define CPM_XFAIL_CYC      16

`endif

// ### inc/cpm_pkg.sv
package cpm_pkg;
    typedef enum logic [2:0] {
        CPM_SRC_RC  = 3'b001,
        CPM_SRC_PLL = 3'b010,
        CPM_SRC_LP  = 3'b100
    } cpm_src_t;

    typedef enum logic [5:0] {
        CPM_RUN     = 6'b000001,
        CPM_SLOW    = 6'b000010,
        CPM_WFI     = 6'b000100,
        CPM_STOP    = 6'b001000,
        CPM_STANDBY = 6'b010000,
        CPM_WAKE    = 6'b100000
    } cpm_state_t;

    typedef enum logic [1:0] {
        CPM_BOOT_FLASH  = 2'b00,
        CPM_BOOT_SERIAL = 2'b01,
        CPM_BOOT_LOADER = 2'b10,
        CPM_BOOT_SRAM   = 2'b11
    } cpm_boot_t;

    // mode request codes written by software
    typedef enum logic [2:0] {
        CPM_REQ_RUN     = 3'h0,
        CPM_REQ_SLOW    = 3'h1,
        CPM_REQ_WFI     = 3'h2,
        CPM_REQ_STOP    = 3'h3,
        CPM_REQ_STANDBY = 3'h4
    } cpm_req_t;
endpackage

// ### rtl/cpm_ctrl.sv
// Added by the designer: register access over APB and the register offsets.
`timescale 1ns/10ps
`default_nettype none
`include "cpm_params.svh"

//
// Contract
// - restart always on internal RC oscillator
// - enable crystal, count its start-up
// - crystal loss forces RC, raises interrupt
// - PLL/prescalers give bus clock ranges
// - USB clock from same PLL
// - boot pins sampled at start-up
// - regulator-disable pin turns regulators off
// - slow mode lowers clock, optional low-power source
// - gating mode stops unused peripheral clocks
// - wait mode stops only processor clock (code also gates usb_clk_en in wait)
// - stop mode gates all, optional oscillators/regulator
// - stop left on interrupt, wake line, RTC
// - stop options keep crystal, flash, regulator
// - standby only with internal regulators
// - standby left on wake pin, RTC alarm
// - RTC counts, alarm and periodic interrupts
module cpm_ctrl (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        crystal_input_pin,
    input  wire logic        pll_lock,
    input  wire logic [1:0]  boot_pins,
    input  wire logic        regulator_disable_pin,
    input  wire logic        standby_wakeup_pin,
    input  wire logic        ext_wake,
    input  wire logic        irq_pending,
    input  wire logic        flash_exec,
    output logic [1:0]       boot_sel,
    output logic [2:0]       sys_src_sel,
    output logic [2:0]       ahb_div,
    output logic [2:0]       apb_div,
    output logic             usb_clk_en,
    output logic             cpu_clk_en,
    output logic             ahb_clk_en,
    output logic [15:0]      apb_clk_en,
    output logic             xtal_en,
    output logic             pll_en,
    output logic             flash_en,
    output logic             main_reg_en,
    output logic             lp_reg_en,
    output logic             core_pwr_en,
    output logic             irq
);

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers: three stages, change counts when 2 and 3 agree
    logic [2:0] xt_s_q, wk_s_q, ew_s_q, rd_s_q;
    logic       xt_f_q, wk_f_q, ew_f_q, rd_f_q, xt_prev_q, wk_prev_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xt_s_q <= 3'h0;
            wk_s_q <= 3'h0;
            ew_s_q <= 3'h0;
            rd_s_q <= 3'h0;
        end else begin
            xt_s_q <= {xt_s_q[1:0], crystal_input_pin};
            wk_s_q <= {wk_s_q[1:0], standby_wakeup_pin};
            ew_s_q <= {ew_s_q[1:0], ext_wake};
            rd_s_q <= {rd_s_q[1:0], regulator_disable_pin};
        end
    end

    // filtered levels, only updated when stages 2 and 3 agree
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xt_f_q    <= 1'b0;
            wk_f_q    <= 1'b0;
            ew_f_q    <= 1'b0;
            rd_f_q    <= 1'b0;
            xt_prev_q <= 1'b0;
            wk_prev_q <= 1'b0;
        end else begin
            if (xt_s_q[1] == xt_s_q[2]) xt_f_q <= xt_s_q[2];
            if (wk_s_q[1] == wk_s_q[2]) wk_f_q <= wk_s_q[2];
            if (ew_s_q[1] == ew_s_q[2]) ew_f_q <= ew_s_q[2];
            if (rd_s_q[1] == rd_s_q[2]) rd_f_q <= rd_s_q[2];
            xt_prev_q <= xt_f_q;
            wk_prev_q <= wk_f_q;
        end
    end

    logic xt_edge, wk_rise;
    assign xt_edge = xt_f_q ^ xt_prev_q;
    assign wk_rise = wk_f_q & ~wk_prev_q;

    ////////////////////////////////////////////////////////////////////
    // registers
    logic [7:0]  ctrl_q;
    logic [2:0]  req_q;
    logic        src_pll_req_q;
    logic [4:0]  irq_stat_q, irq_mask_q, irq_set;
    logic [15:0] pcg_q;
    logic [7:0]  div_q;
    logic [15:0] rtc_cnt_q, rtc_alm_q, rtc_per_q, rtc_pcnt_q;
    logic        boot_done_q;

    logic wr, rd;
    assign wr = psel & penable & pwrite;
    assign rd = psel & penable & ~pwrite;

    // single-cycle access phase, never stalls
    assign pready = 1'b1;

    logic hit;
    always_comb begin
        unique case (paddr)
            `CPM_CTRL_OFS, `CPM_MODE_OFS, `CPM_SRC_OFS, `CPM_STAT_OFS, `CPM_IRQ_STAT_OFS,
            `CPM_IRQ_MASK_OFS, `CPM_PCG_OFS, `CPM_DIV_OFS, `CPM_RTC_CNT_OFS,
            `CPM_RTC_ALM_OFS, `CPM_RTC_PER_OFS: hit = 1'b1;
            default: hit = 1'b0;
        endcase
    end
    assign pslverr = psel & penable & ~hit;

    ////////////////////////////////////////////////////////////////////
    // power state machine
    cpm_pkg::cpm_state_t st_q;
    cpm_pkg::cpm_src_t   src_q;
    logic [13:0] xcnt_q;
    logic        xrdy_q;
    logic [4:0]  fail_cnt_q;
    logic        xfail_ev, alarm_ev, period_ev, stop_wake, sb_wake;

    // single-supply scheme only: standby refused with regulators off
    logic sb_allowed;
    assign sb_allowed = ~rd_f_q;

    assign stop_wake = irq_pending | ew_f_q | (ctrl_q[`CPM_CTRL_RTC_RUN] & alarm_ev);
    assign sb_wake   = wk_rise | alarm_ev;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q <= cpm_pkg::CPM_RUN;
        end else begin
            unique case (st_q)
                cpm_pkg::CPM_RUN, cpm_pkg::CPM_SLOW: begin
                    if (wr && paddr == `CPM_MODE_OFS) begin
                        unique case (pwdata[2:0])
                            cpm_pkg::CPM_REQ_SLOW:    st_q <= cpm_pkg::CPM_SLOW;
                            cpm_pkg::CPM_REQ_WFI:     st_q <= cpm_pkg::CPM_WFI;
                            cpm_pkg::CPM_REQ_STOP:    st_q <= cpm_pkg::CPM_STOP;
                            cpm_pkg::CPM_REQ_STANDBY: st_q <= sb_allowed ? cpm_pkg::CPM_STANDBY : st_q;
                            default:                  st_q <= cpm_pkg::CPM_RUN;
                        endcase
                    end
                end
                cpm_pkg::CPM_WFI:     if (irq_pending) st_q <= cpm_pkg::CPM_WAKE;
                cpm_pkg::CPM_STOP:    if (stop_wake) st_q <= cpm_pkg::CPM_WAKE;
                cpm_pkg::CPM_STANDBY: if (sb_wake) st_q <= cpm_pkg::CPM_WAKE;
                cpm_pkg::CPM_WAKE:    st_q <= cpm_pkg::CPM_RUN;
                default:              st_q <= cpm_pkg::CPM_RUN;
            endcase
        end
    end

    // requested mode register, readable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) req_q <= 3'h0;
        else if (wr && paddr == `CPM_MODE_OFS) req_q <= pwdata[2:0];
        else if (st_q == cpm_pkg::CPM_WAKE) req_q <= 3'h0;
    end

    ////////////////////////////////////////////////////////////////////
    // crystal start-up counter; restarted on every wake
    logic xtal_on;
    assign xtal_on = (st_q == cpm_pkg::CPM_RUN) | (st_q == cpm_pkg::CPM_WFI) |
                     ((st_q == cpm_pkg::CPM_SLOW) & ~ctrl_q[`CPM_CTRL_SLOW_LP]) |
                     ((st_q == cpm_pkg::CPM_STOP) & (ctrl_q[`CPM_CTRL_KEEP_XTAL] | ~ctrl_q[`CPM_CTRL_STOP_OSC]));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xcnt_q <= 14'h0;
            xrdy_q <= 1'b0;
        end else if (!xtal_on || st_q == cpm_pkg::CPM_WAKE) begin
            xcnt_q <= 14'h0;
            xrdy_q <= ctrl_q[`CPM_CTRL_KEEP_XTAL] & xrdy_q & (st_q == cpm_pkg::CPM_WAKE);
        end else if (xcnt_q == 14'(`CPM_XTAL_START_CYC - 1)) begin
            xrdy_q <= 1'b1;
        end else begin
            xcnt_q <= xcnt_q + 14'h1;
        end
    end

    // crystal loss: no pin edge within the window while usable
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) fail_cnt_q <= 5'h0;
        else if (!xrdy_q || xt_edge) fail_cnt_q <= 5'h0;
        else if (fail_cnt_q != 5'(`CPM_XFAIL_CYC)) fail_cnt_q <= fail_cnt_q + 5'h1;
    end
    assign xfail_ev = xrdy_q & (fail_cnt_q == 5'(`CPM_XFAIL_CYC - 1)) & ~xt_edge;

    ////////////////////////////////////////////////////////////////////
    // source select: RC after reset and wake, fallback stays until rewrite
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            src_q <= cpm_pkg::CPM_SRC_RC;
            src_pll_req_q <= 1'b0;
        end else if (st_q == cpm_pkg::CPM_WAKE) begin
            src_q <= cpm_pkg::CPM_SRC_RC;
            src_pll_req_q <= 1'b0;
        end else if (xfail_ev) begin
            src_q <= cpm_pkg::CPM_SRC_RC;
            src_pll_req_q <= 1'b0;
        end else begin
            if (wr && paddr == `CPM_SRC_OFS) src_pll_req_q <= pwdata[0];
            if (st_q == cpm_pkg::CPM_SLOW && ctrl_q[`CPM_CTRL_SLOW_LP]) src_q <= cpm_pkg::CPM_SRC_LP;
            else if (src_pll_req_q && xrdy_q && pll_lock) src_q <= cpm_pkg::CPM_SRC_PLL;
            else src_q <= cpm_pkg::CPM_SRC_RC;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // boot source captured once after reset release
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            boot_done_q <= 1'b0;
            boot_sel    <= 2'h0;
        end else if (!boot_done_q) begin
            boot_done_q <= 1'b1;
            boot_sel    <= boot_pins;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // RTC keeps counting in every state; alarm and periodic tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rtc_cnt_q  <= 16'h0;
            rtc_pcnt_q <= 16'h0;
        end else begin
            rtc_cnt_q  <= (wr && paddr == `CPM_RTC_CNT_OFS) ? pwdata[15:0] : rtc_cnt_q + 16'h1;
            rtc_pcnt_q <= period_ev ? 16'h0 : rtc_pcnt_q + 16'h1;
        end
    end
    assign alarm_ev  = (rtc_cnt_q == rtc_alm_q);
    assign period_ev = (rtc_pcnt_q == rtc_per_q);

    ////////////////////////////////////////////////////////////////////
    // software registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q    <= `CPM_CTRL_RST;
            irq_mask_q <= 5'h0;
            pcg_q     <= 16'h0;
            div_q     <= `CPM_DIV_RST;
            rtc_alm_q <= 16'hFFFF;
            rtc_per_q <= `CPM_RTC_PER_RST;
        end else if (wr) begin
            if (paddr == `CPM_CTRL_OFS) ctrl_q <= pwdata[7:0];
            if (paddr == `CPM_IRQ_MASK_OFS) irq_mask_q <= pwdata[4:0];
            if (paddr == `CPM_PCG_OFS) pcg_q <= pwdata[15:0];
            if (paddr == `CPM_DIV_OFS) div_q <= pwdata[7:0];
            if (paddr == `CPM_RTC_ALM_OFS) rtc_alm_q <= pwdata[15:0];
            if (paddr == `CPM_RTC_PER_OFS) rtc_per_q <= pwdata[15:0];
        end
    end

    // sticky interrupt status, write one to clear, set wins
    always_comb begin
        irq_set = 5'h0;
        irq_set[`CPM_IRQ_XFAIL]  = xfail_ev;
        // one pulse as the count ends; a level here would defeat the clear
        irq_set[`CPM_IRQ_XRDY]   = ~xrdy_q & xtal_on & (xcnt_q == 14'(`CPM_XTAL_START_CYC - 1));
        irq_set[`CPM_IRQ_ALARM]  = alarm_ev;
        irq_set[`CPM_IRQ_PERIOD] = period_ev;
        irq_set[`CPM_IRQ_WAKE]   = (st_q == cpm_pkg::CPM_WAKE);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) irq_stat_q <= 5'h0;
        else irq_stat_q <= (irq_stat_q & ~((wr && paddr == `CPM_IRQ_STAT_OFS) ? pwdata[4:0] : 5'h0))
                           | irq_set;
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    // read mux
    always_comb begin
        prdata = 32'h0000_0000;
        if (rd) begin
            unique case (paddr)
                `CPM_CTRL_OFS:     prdata = {24'h0, ctrl_q};
                `CPM_MODE_OFS:     prdata = {29'h0, req_q};
                `CPM_SRC_OFS:      prdata = {25'h0, src_q, 3'h0, src_pll_req_q};
                `CPM_STAT_OFS:     prdata = {20'h0, boot_sel, st_q, rd_f_q, xrdy_q, pll_lock, flash_exec};
                `CPM_IRQ_STAT_OFS: prdata = {27'h0, irq_stat_q};
                `CPM_IRQ_MASK_OFS: prdata = {27'h0, irq_mask_q};
                `CPM_PCG_OFS:      prdata = {16'h0, pcg_q};
                `CPM_DIV_OFS:      prdata = {24'h0, div_q};
                `CPM_RTC_CNT_OFS:  prdata = {16'h0, rtc_cnt_q};
                `CPM_RTC_ALM_OFS:  prdata = {16'h0, rtc_alm_q};
                `CPM_RTC_PER_OFS:  prdata = {16'h0, rtc_per_q};
                default:           prdata = 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // clock and power enables
    logic running, stopped;
    assign running = (st_q == cpm_pkg::CPM_RUN) | (st_q == cpm_pkg::CPM_SLOW) | (st_q == cpm_pkg::CPM_WAKE);
    assign stopped = (st_q == cpm_pkg::CPM_STOP) | (st_q == cpm_pkg::CPM_STANDBY);

    assign sys_src_sel = src_q;
    // sram-only rate needs divider 0; flash code kept at least /1 step, 60 MHz ceiling
    assign ahb_div    = (flash_exec && div_q[2:0] == 3'h0) ? 3'h1 : div_q[2:0];
    assign apb_div    = (div_q[6:4] == 3'h0) ? 3'h1 : div_q[6:4];
    assign usb_clk_en = running & (src_q == cpm_pkg::CPM_SRC_PLL);
    assign cpu_clk_en = running;
    assign ahb_clk_en = ~stopped;
    // gating happens whenever pcg bits are set; all gated in stop
    assign apb_clk_en = stopped ? 16'h0 : ~pcg_q;
    assign xtal_en    = xtal_on;
    assign pll_en     = xtal_on & ~stopped & (st_q != cpm_pkg::CPM_SLOW || !ctrl_q[`CPM_CTRL_SLOW_LP]);
    assign flash_en   = ~stopped | ((st_q == cpm_pkg::CPM_STOP) & ctrl_q[`CPM_CTRL_KEEP_FL]);
    assign main_reg_en = ~rd_f_q & (st_q != cpm_pkg::CPM_STANDBY) &
                         ~((st_q == cpm_pkg::CPM_STOP) & ctrl_q[`CPM_CTRL_STOP_REG] &
                           ~ctrl_q[`CPM_CTRL_KEEP_REG]);
    assign lp_reg_en  = ~rd_f_q;
    assign core_pwr_en = (st_q != cpm_pkg::CPM_STANDBY);

endmodule
`default_nettype wire

// ### tb/cpm_partner.sv
`timescale 1ns/10ps
`default_nettype none
module cpm_partner (
    input  wire logic       pclk,
    input  wire logic       xtal_en,
    input  wire logic       pll_en,
    input  wire logic       xtal_run,
    input  wire logic [1:0] boot_code,
    input  wire logic       reg_off,
    output logic            crystal_input_pin,
    output logic [1:0]      boot_pins,
    output logic            regulator_disable_pin,
    output logic            pll_lock
);
    logic [2:0] osc_q = 3'd0;
    logic [4:0] lock_q = 5'd0;
    ////////////////////////////////////////////////////////////////
    // board straps held steady, never left floating
    assign boot_pins = boot_code;
    assign regulator_disable_pin = reg_off;
    // slower than pclk so the pin filter sees each level four times; stands still when dead
    always @(posedge pclk) begin
        if (xtal_en && xtal_run) begin
            osc_q <= osc_q + 3'd1;
        end
    end
    assign crystal_input_pin = osc_q[2];
    // lock needs a live reference for 20 cycles
    always @(posedge pclk) begin
        if (!pll_en || !xtal_run) begin
            lock_q <= 5'd0;
        end else if (lock_q != 5'd20) begin
            lock_q <= lock_q + 5'd1;
        end
    end
    assign pll_lock = (lock_q == 5'd20);
endmodule
`default_nettype wire

// ### tb/cpm_properties.sv
`timescale 1ns/10ps
`default_nettype none
`include "cpm_params.svh"
module cpm_properties (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic        pslverr,
    input wire logic        regulator_disable_pin,
    input wire logic        standby_wakeup_pin,
    input wire logic        ext_wake,
    input wire logic        irq_pending,
    input wire logic [2:0]  sys_src_sel,
    input wire logic        cpu_clk_en,
    input wire logic        ahb_clk_en,
    input wire logic [15:0] apb_clk_en,
    input wire logic        main_reg_en,
    input wire logic        lp_reg_en,
    input wire logic        core_pwr_en
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    // source select write seen on the bus
    wire logic src_wr = psel && penable && pwrite && (paddr == `CPM_SRC_OFS);
    ////////////////////////////////////////////////////////////////
    sequence s_mode_req(logic [2:0] code);
        psel && penable && pwrite && (paddr == `CPM_MODE_OFS) && (pwdata[2:0] == code);
    endsequence
    sequence s_stopped;
        !cpu_clk_en && !ahb_clk_en && core_pwr_en;
    endsequence
    a_unmapped_err: assert property (psel && penable && paddr[1:0] == 2'b00 |-> pslverr == (paddr > 12'h028))
        else $error("slave error flag wrong for address");
    a_wfi_gates: assert property (s_mode_req(cpm_pkg::CPM_REQ_WFI) ##1 !irq_pending [*4] |-> !cpu_clk_en && ahb_clk_en)
        else $error("wait mode did not stop only the cpu clock");
    a_wfi_wakes: assert property (!cpu_clk_en && ahb_clk_en && irq_pending |-> ##[1:3] cpu_clk_en)
        else $error("wait mode ignored a pending interrupt");
    a_stop_gates: assert property (s_mode_req(cpm_pkg::CPM_REQ_STOP) ##1 (!ext_wake && !irq_pending) [*4]
        |-> !cpu_clk_en && !ahb_clk_en && apb_clk_en == 16'h0000)
        else $error("stop mode left a clock running");
    a_stop_wake: assert property (s_stopped ##0 ext_wake |-> ##[1:8] cpu_clk_en)
        else $error("stop mode missed the wake line");
    a_stby_wake: assert property (!core_pwr_en && $rose(standby_wakeup_pin) |-> ##[1:10] core_pwr_en)
        else $error("standby missed the wake pin");
    a_wake_on_rc: assert property ($rose(cpu_clk_en) |-> ##[0:2] sys_src_sel == cpm_pkg::CPM_SRC_RC)
        else $error("restart not on the rc oscillator");
    a_rc_sticky: assert property (sys_src_sel == cpm_pkg::CPM_SRC_RC ##1 sys_src_sel == cpm_pkg::CPM_SRC_PLL
        |-> $past(src_wr, 1) || $past(src_wr, 2) || $past(src_wr, 3))
        else $error("pll taken back without software");
    a_regdis_off: assert property (regulator_disable_pin [*6] |-> !main_reg_en && !lp_reg_en && core_pwr_en)
        else $error("regulators or standby active with regulators disabled");
endmodule
bind cpm_ctrl cpm_properties cpm_properties_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pslverr,
    .regulator_disable_pin, .standby_wakeup_pin, .ext_wake, .irq_pending, .sys_src_sel, .cpu_clk_en,
    .ahb_clk_en, .apb_clk_en, .main_reg_en, .lp_reg_en, .core_pwr_en);
`default_nettype wire

// ### tb/cpm_ctrl_tb.sv
`timescale 1ns/10ps
`default_nettype none
`include "cpm_params.svh"
module cpm_ctrl_tb;
    typedef struct packed {logic w; logic [11:0] a; logic [31:0] d; logic [31:0] x; logic e;} cpm_row_t;
    // write flag, address, data, expected read, expected slave error
    localparam cpm_row_t ROWS [6] = '{
        '{1'b0, `CPM_CTRL_OFS, 32'h0000_0000, 32'h0000_0040, 1'b0},
        '{1'b0, `CPM_RTC_ALM_OFS, 32'h0000_0000, 32'h0000_FFFF, 1'b0},
        '{1'b0, `CPM_RTC_PER_OFS, 32'h0000_0000, 32'h0000_0100, 1'b0},
        '{1'b1, `CPM_PCG_OFS, 32'h0000_0005, 32'h0000_0005, 1'b0},
        '{1'b1, `CPM_RTC_ALM_OFS, 32'h0000_1234, 32'h0000_1234, 1'b0},
        '{1'b1, 12'h030, 32'hFFFF_FFFF, 32'h0000_0000, 1'b1}};
    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, rerr, irq;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rdat, cnt;
    logic        xtal_run, reg_off, standby_wakeup_pin, ext_wake, irq_pending, flash_exec;
    logic [1:0]  boot_code, boot_pins, boot_sel;
    logic        crystal_input_pin, pll_lock, regulator_disable_pin, usb_clk_en, cpu_clk_en, ahb_clk_en;
    logic        xtal_en, pll_en, flash_en, main_reg_en, lp_reg_en, core_pwr_en;
    logic [2:0]  sys_src_sel, ahb_div, apb_div;
    logic [15:0] apb_clk_en;
    int          err_total = 0;
    int          n_tests = 0;
    cpm_ctrl cpm_ctrl_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
        .crystal_input_pin, .pll_lock, .boot_pins, .regulator_disable_pin, .standby_wakeup_pin, .ext_wake,
        .irq_pending, .flash_exec, .boot_sel, .sys_src_sel, .ahb_div, .apb_div, .usb_clk_en, .cpu_clk_en,
        .ahb_clk_en, .apb_clk_en, .xtal_en, .pll_en, .flash_en, .main_reg_en, .lp_reg_en, .core_pwr_en, .irq);
    cpm_partner cpm_partner_i (.pclk, .xtal_en, .pll_en, .xtal_run, .boot_code, .reg_off,
        .crystal_input_pin, .boot_pins, .regulator_disable_pin, .pll_lock);
    ////////////////////////////////////////////////////////////////
    always #50 pclk = ~pclk;
    task automatic test_done();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // one transfer; request held until pready is seen high
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) begin
            @(posedge pclk);
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    // hang guard, well past the crystal start-up wait
    initial begin
        tick(40000);
        err_total++;
        test_done();
    end
    ////////////////////////////////////////////////////////////////
    initial begin
        {pclk, presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {reg_off, standby_wakeup_pin, ext_wake, irq_pending, flash_exec, boot_code} = '0;
        xtal_run = 1'b1;
        tick(2);
        presetn <= 1'b1;
        tick(1);
        foreach (ROWS[k]) begin
            if (ROWS[k].w) begin
                apb(1'b1, ROWS[k].a, ROWS[k].d);
            end
            apb(1'b0, ROWS[k].a, 32'h0000_0000);
            chk(rdat, ROWS[k].x);
            chk({31'h0, rerr}, {31'h0, ROWS[k].e});
        end
        chk({16'h0, apb_clk_en}, 32'h0000_FFFA);
        // every strap code through a fresh start-up
        for (int b = 0; b < 4; b++) begin
            presetn <= 1'b0;
            boot_code <= 2'(b);
            tick(2);
            presetn <= 1'b1;
            tick(2);
            apb(1'b0, `CPM_STAT_OFS, 32'h0000_0000);
            chk({28'h0, rdat[11:10], boot_sel}, 32'(b * 5));
            chk({28'h0, xtal_en, sys_src_sel}, 32'h0000_0009);
        end
        // crystal not usable before its start-up count ends
        tick(9880);
        apb(1'b0, `CPM_IRQ_STAT_OFS, 32'h0000_0000);
        chk(rdat & 32'h0000_0002, 32'h0000_0000);
        tick(150);
        apb(1'b0, `CPM_IRQ_STAT_OFS, 32'h0000_0000);
        chk(rdat & 32'h0000_000B, 32'h0000_000A);
        chk({31'h0, irq}, 32'h0000_0000);
        apb(1'b1, `CPM_IRQ_MASK_OFS, 32'h0000_0003);
        chk({31'h0, irq}, 32'h0000_0001);
        apb(1'b1, `CPM_IRQ_STAT_OFS, 32'h0000_0002);
        chk({31'h0, irq}, 32'h0000_0000);
        apb(1'b1, `CPM_RTC_PER_OFS, 32'h0000_FFFF);
        apb(1'b0, `CPM_RTC_CNT_OFS, 32'h0000_0000);
        cnt = rdat;
        apb(1'b0, `CPM_RTC_CNT_OFS, 32'h0000_0000);
        chk(rdat - cnt, 32'h0000_0003);
        // switch to the pll with flash limiting the bus divider
        flash_exec <= 1'b1;
        apb(1'b1, `CPM_DIV_OFS, 32'h0000_0000);
        apb(1'b1, `CPM_SRC_OFS, 32'h0000_0001);
        for (int i = 0; i < 100 && sys_src_sel !== cpm_pkg::CPM_SRC_PLL; i++) begin
            tick(1);
        end
        chk({24'h0, usb_clk_en, pll_en, ahb_div, sys_src_sel}, 32'h0000_00CA);
        chk({29'h0, apb_div}, 32'h0000_0001);
        flash_exec <= 1'b0;
        tick(2);
        chk({29'h0, ahb_div}, 32'h0000_0000);
        // crystal dies, then comes back: source must stay on rc
        xtal_run <= 1'b0;
        tick(40);
        chk({28'h0, irq, sys_src_sel}, 32'h0000_0009);
        xtal_run <= 1'b1;
        tick(40);
        apb(1'b0, `CPM_IRQ_STAT_OFS, 32'h0000_0000);
        chk({rdat[31:4], rdat[0], sys_src_sel}, 32'h0000_0009);
        apb(1'b1, `CPM_IRQ_STAT_OFS, 32'h0000_0001);
        chk({31'h0, irq}, 32'h0000_0000);
        apb(1'b1, `CPM_MODE_OFS, 32'h0000_0002);
        tick(4);
        chk({30'h0, cpu_clk_en, ahb_clk_en}, 32'h0000_0001);
        irq_pending <= 1'b1;
        tick(6);
        chk({28'h0, cpu_clk_en, sys_src_sel}, 32'h0000_0009);
        irq_pending <= 1'b0;
        // stop with crystal kept, then with oscillators off
        for (int s = 0; s < 2; s++) begin
            apb(1'b1, `CPM_CTRL_OFS, s ? 32'h0000_0002 : 32'h0000_0018);
            apb(1'b1, `CPM_MODE_OFS, 32'h0000_0003);
            tick(4);
            chk({12'h0, flash_en, xtal_en, cpu_clk_en, ahb_clk_en, apb_clk_en}, 32'((1 - s) * 3) << 18);
            ext_wake <= 1'b1;
            tick(8);
            chk({31'h0, cpu_clk_en}, 32'h0000_0001);
            ext_wake <= 1'b0;
        end
        apb(1'b1, `CPM_CTRL_OFS, 32'h0000_0041);
        apb(1'b1, `CPM_MODE_OFS, 32'h0000_0001);
        tick(4);
        chk({29'h0, sys_src_sel}, 32'h0000_0004);
        apb(1'b1, `CPM_MODE_OFS, 32'h0000_0000);
        apb(1'b1, `CPM_MODE_OFS, 32'h0000_0004);
        tick(4);
        chk({31'h0, core_pwr_en}, 32'h0000_0000);
        standby_wakeup_pin <= 1'b1;
        tick(12);
        chk({29'h0, core_pwr_en, cpu_clk_en, sys_src_sel[0]}, 32'h0000_0007);
        standby_wakeup_pin <= 1'b0;
        // external supply: regulators off and standby refused
        reg_off <= 1'b1;
        tick(8);
        apb(1'b1, `CPM_MODE_OFS, 32'h0000_0004);
        tick(4);
        chk({29'h0, main_reg_en, lp_reg_en, core_pwr_en}, 32'h0000_0001);
        test_done();
    end
endmodule
`default_nettype wire
